// *** rtl/discrete_packet_defs.svh ***
// Register map, field positions and reset values of the discrete packet builder
`ifndef DISCRETE_PACKET_DEFS_SVH
`define DISCRETE_PACKET_DEFS_SVH
`define OFS_CTRL 4'h0
`define OFS_INTERVAL 4'h4
`define OFS_PER_PKT 4'h8
`define OFS_STATUS 4'hC
`define CTL_EN 8
`define CTL_ABS 9
`define CTL_FMT_LO 10
`define CTL_LEN_LO 3
`define CSW_RSV_LO 8
`define FLAG_ABS 6
`define FLAG_FMT_LO 2
`define DATA_FORMAT 4'h1
`define RST_INTERVAL 32'h0000_0028
`define RST_PER_PKT 16'h0001
`define STATE_BITS 32
`define TS_WORDS 2'h3
`endif

// *** rtl/discrete_packet_pkg.sv ***
// Types of the discrete packet builder
package discrete_packet_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CSW = 4'b0010,
    S_TS = 4'b0100,
    S_ST = 4'b1000
  } fsm_e;
  typedef struct packed {
    logic [15:0] data;
    logic first;
    logic last;
  } word_s;
  typedef struct packed {
    logic en;
    logic abs;
    logic [1:0] fmt;
    logic [4:0] len;
    logic [1:0] mode;
  } ctrl_s;
  typedef struct packed {
    fsm_e fsm;
    logic [1:0] idx;
    logic [15:0] evt_cnt;
    logic [31:0] csw;
    logic [47:0] rtc;
    logic [31:0] tick;
    logic [31:0] last_raw;
    logic primed;
    logic pend;
    logic [63:0] pend_ts;
    logic [31:0] pend_st;
    logic [15:0] dropped;
    ctrl_s ctl;
    logic [31:0] interval;
    logic [15:0] per_pkt;
    logic ack;
    logic [31:0] rdata;
    logic ovalid;
    word_s oword;
  } core_s;
endpackage

// *** rtl/discrete_event_packet_builder.sv ***
// Discrete event capture and packet body framer with Avalon-MM control
//
// How it works
// - Packets are always tagged format one
// - One to thirty-two input states per event
// - Word bits 31..8 reserved, driven zero
// - Bits 7..3 hold event width, zero=32
// - Bits 2..0 mode, bit 2 reserved
// - Mode bit0: on change or interval
// - Mode bit1: LSB or MSB state alignment
// - Each event carries states and time
// - LSB alignment: state word bit n is input n
// - Eight byte timestamp precedes each state word
// - Relative time: 48-bit counter, top zero
// - Absolute time when flag bit 6 set
// - Channel word emitted low half first
// - Timestamp then states, low halves first
// - Repeat N events, then mark last word
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "discrete_packet_defs.svh"

module discrete_event_packet_builder #(
  parameter int N_IN = 32
) (
  input wire logic CLK, // 40 MHz clock
  input wire logic RSTN, // Async reset, low
  input wire logic [3:0] AV_ADDRESS, // Byte address
  input wire logic AV_READ, // Read request
  input wire logic AV_WRITE, // Write request
  input wire logic [31:0] AV_WRITEDATA, // Write data
  input wire logic [3:0] AV_BYTEENABLE, // Byte lanes
  output logic [31:0] AV_READDATA, // Read data
  output logic AV_WAITREQUEST, // Stall
  input wire logic [N_IN-1:0] DISC_IN, // Discrete inputs
  input wire logic [63:0] ABS_TIME, // Absolute time
  output logic [3:0] DATA_FORMAT, // Packet format
  output logic [7:0] PKT_FLAGS, // Time flags
  output discrete_packet_pkg::word_s OUT_WORD, // Body word
  output logic OUT_VALID, // Word valid
  input wire logic OUT_READY // Sink ready
);

  // Refuse widths the state word cannot hold
  if (N_IN < 1 || N_IN > `STATE_BITS) begin : g_bad_width
    $error("N_IN must be 1 to 32");
  end

  discrete_packet_pkg::core_s s_r;
  discrete_packet_pkg::core_s s_nxt;

  logic [31:0] raw;
  logic [31:0] sample;
  logic tick_fire;
  logic trig;
  logic load;
  logic [15:0] cnt_inc;
  logic [31:0] wmask;
  logic [31:0] rmux;
  logic rd_take;
  logic wr_take;

  // Width in bits; zero stands for 32
  function automatic logic [5:0] ev_bits(input logic [4:0] len);
    ev_bits = (len == 5'h0) ? 6'd32 : {1'b0, len};
  endfunction

  function automatic logic [31:0] len_mask(input logic [4:0] len);
    logic [32:0] m;
    m = (33'h1 << ev_bits(len)) - 33'h1;
    len_mask = m[31:0];
  endfunction

  // Place the captured bits at the low or high end
  function automatic logic [31:0] align(input logic [31:0] v, input logic [4:0] len, input logic msb);
    logic [5:0] sh;
    sh = 6'd32 - ev_bits(len);
    align = msb ? (v << sh) : v;
  endfunction

  function automatic logic [15:0] half(input logic [31:0] v, input logic hi);
    half = hi ? v[31:16] : v[15:0];
  endfunction

  // Byte lanes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    lane_mask = m;
  endfunction

  // Readback image of the control register
  function automatic logic [31:0] ctrl_rd(input discrete_packet_pkg::ctrl_s c);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[2:0] = {1'b0, c.mode};
    v[`CTL_LEN_LO +: 5] = c.len;
    v[`CTL_EN] = c.en;
    v[`CTL_ABS] = c.abs;
    v[`CTL_FMT_LO +: 2] = c.fmt;
    ctrl_rd = v;
  endfunction

  // Register image at a byte offset; unmapped offsets read zero
  function automatic logic [31:0] reg_rd(input logic [3:0] a, input discrete_packet_pkg::core_s s);
    logic [31:0] v;
    unique case (a)
      `OFS_CTRL: v = ctrl_rd(s.ctl);
      `OFS_INTERVAL: v = s.interval;
      `OFS_PER_PKT: v = {16'h0000, s.per_pkt};
      `OFS_STATUS: v = {s.dropped, 14'h0000, s.pend, !s.fsm[0]};
      default: v = 32'h0000_0000;
    endcase
    reg_rd = v;
  endfunction

  // Channel word: reserved top, width, reserved mode bit, mode
  function automatic logic [31:0] csw_of(input discrete_packet_pkg::ctrl_s c);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[7:3] = c.len;
    v[2] = 1'b0;
    v[1:0] = c.mode;
    csw_of = v;
  endfunction

  // Timestamp of a capture: absolute time, or the free-running count
  function automatic logic [63:0] ts_of(input logic use_abs, input logic [63:0] abs_t, input logic [47:0] rtc);
    logic [63:0] v;
    if (use_abs) begin
      v = abs_t;
    end else begin
      v = {16'h0000, rtc};
    end
    ts_of = v;
  endfunction

  assign raw = 32'(DISC_IN);
  assign sample = raw & len_mask(s_r.ctl.len);
  assign tick_fire = s_r.ctl.mode[0] && (s_r.tick == 32'h0);
  assign load = !s_r.ovalid || OUT_READY;
  assign cnt_inc = s_r.evt_cnt + 16'h1;
  assign wmask = lane_mask(AV_BYTEENABLE);
  assign rmux = reg_rd(AV_ADDRESS, s_r);

  // Reads load on the stall cycle, writes land on the answer cycle
  assign rd_take = AV_READ && !s_r.ack;
  assign wr_take = AV_WRITE && s_r.ack;

  // Event trigger: interval tick, or first sample or change after enable
  always_comb begin
    if (!s_r.ctl.en) begin
      trig = 1'b0;
    end else if (s_r.ctl.mode[0]) begin
      trig = tick_fire;
    end else begin
      trig = !s_r.primed || (sample != s_r.last_raw);
    end
  end

  always_comb begin
    logic [31:0] wv;
    logic [31:0] cur;
    wv = 32'h0;
    cur = 32'h0;
    s_nxt = s_r;
    s_nxt.ack = (AV_READ || AV_WRITE) && !s_r.ack;
    s_nxt.rtc = s_r.rtc + 48'h1;
    if (rd_take) begin
      s_nxt.rdata = rmux;
    end
    if (wr_take) begin
      cur = rmux;
      wv = (AV_WRITEDATA & wmask) | (cur & ~wmask);
      unique case (AV_ADDRESS)
        `OFS_CTRL: begin
          s_nxt.ctl.mode = {wv[1], wv[0]};
          s_nxt.ctl.len = wv[`CTL_LEN_LO +: 5];
          s_nxt.ctl.en = wv[`CTL_EN];
          s_nxt.ctl.abs = wv[`CTL_ABS];
          s_nxt.ctl.fmt = wv[`CTL_FMT_LO +: 2];
        end
        `OFS_INTERVAL: s_nxt.interval = wv;
        `OFS_PER_PKT: s_nxt.per_pkt = wv[15:0];
        `OFS_STATUS: s_nxt.dropped = 16'h0;
        default: s_nxt.interval = s_r.interval;
      endcase
    end
    // Interval timer
    if (!s_r.ctl.en || !s_r.ctl.mode[0]) begin
      s_nxt.tick = 32'h0;
    end else if (tick_fire) begin
      s_nxt.tick = (s_r.interval == 32'h0) ? 32'h0 : s_r.interval - 32'h1;
    end else begin
      s_nxt.tick = s_r.tick - 32'h1;
    end
    if (!s_r.ctl.en) begin
      s_nxt.primed = 1'b0;
    end
    // Output word register
    if (s_r.ovalid && OUT_READY) begin
      s_nxt.ovalid = 1'b0;
    end
    unique case (s_r.fsm)
      discrete_packet_pkg::S_IDLE: begin
        if (s_r.pend) begin
          s_nxt.csw = csw_of(s_r.ctl);
          s_nxt.fsm = discrete_packet_pkg::S_CSW;
          s_nxt.idx = 2'h0;
          s_nxt.evt_cnt = 16'h0;
        end
      end
      discrete_packet_pkg::S_CSW: begin
        if (load) begin
          s_nxt.ovalid = 1'b1;
          s_nxt.oword.data = half(s_r.csw, s_r.idx[0]);
          s_nxt.oword.first = !s_r.idx[0];
          s_nxt.oword.last = 1'b0;
          s_nxt.idx = s_r.idx + 2'h1;
          if (s_r.idx[0]) begin
            s_nxt.fsm = discrete_packet_pkg::S_TS;
            s_nxt.idx = 2'h0;
          end
        end
      end
      discrete_packet_pkg::S_TS: begin
        if (load && s_r.pend) begin
          s_nxt.ovalid = 1'b1;
          s_nxt.oword.data = s_r.pend_ts[{s_r.idx, 4'h0} +: 16];
          s_nxt.oword.first = 1'b0;
          s_nxt.oword.last = 1'b0;
          s_nxt.idx = s_r.idx + 2'h1;
          if (s_r.idx == `TS_WORDS) begin
            s_nxt.fsm = discrete_packet_pkg::S_ST;
            s_nxt.idx = 2'h0;
          end
        end
      end
      discrete_packet_pkg::S_ST: begin
        if (load) begin
          s_nxt.ovalid = 1'b1;
          s_nxt.oword.data = half(s_r.pend_st, s_r.idx[0]);
          s_nxt.oword.first = 1'b0;
          s_nxt.oword.last = 1'b0;
          s_nxt.idx = s_r.idx + 2'h1;
          if (s_r.idx[0]) begin
            s_nxt.pend = 1'b0;
            s_nxt.evt_cnt = cnt_inc;
            s_nxt.idx = 2'h0;
            s_nxt.fsm = discrete_packet_pkg::S_TS;
            if (cnt_inc >= s_r.per_pkt) begin
              s_nxt.oword.last = 1'b1;
              s_nxt.fsm = discrete_packet_pkg::S_IDLE;
            end
          end
        end
      end
    endcase
    // Capture after the emitter so a freed slot is reused at once
    if (trig) begin
      s_nxt.primed = 1'b1;
      s_nxt.last_raw = sample;
      if (!s_nxt.pend) begin
        s_nxt.pend = 1'b1;
        s_nxt.pend_st = align(sample, s_r.ctl.len, s_r.ctl.mode[1]);
        s_nxt.pend_ts = ts_of(s_r.ctl.abs, ABS_TIME, s_r.rtc);
      end else if (s_r.dropped != 16'hFFFF) begin
        s_nxt.dropped = s_r.dropped + 16'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r <= '0;
      s_r.fsm <= discrete_packet_pkg::S_IDLE;
      s_r.interval <= `RST_INTERVAL;
      s_r.per_pkt <= `RST_PER_PKT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign AV_WAITREQUEST = (AV_READ || AV_WRITE) && !s_r.ack;
  assign AV_READDATA = s_r.rdata;
  assign DATA_FORMAT = `DATA_FORMAT;
  // Time flags follow the control register
  always_comb begin
    PKT_FLAGS = 8'h00;
    PKT_FLAGS[`FLAG_ABS] = s_r.ctl.abs;
    PKT_FLAGS[`FLAG_FMT_LO +: 2] = s_r.ctl.fmt;
  end
  assign OUT_WORD = s_r.oword;
  assign OUT_VALID = s_r.ovalid;

endmodule // discrete_event_packet_builder

// *** test/discrete_event_packet_builder_props.sv ***
// Port assertions of the discrete packet builder
`timescale 1ns/100ps
module discrete_event_packet_builder_props (
  input wire logic CLK, // Clock
  input wire logic RSTN, // Reset, low
  input wire logic [3:0] DATA_FORMAT, // Format
  input wire logic [7:0] PKT_FLAGS, // Flags
  input wire discrete_packet_pkg::word_s OUT_WORD, // Word
  input wire logic OUT_VALID, // Valid
  input wire logic OUT_READY // Ready
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_fmt; DATA_FORMAT == 4'h1; endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_flg; (PKT_FLAGS & 8'hB3) == 8'h00; endproperty
  a_flg: assert property (p_flg) else $error("flags");
  property p_rsv; OUT_VALID && OUT_WORD.first |-> OUT_WORD.data[15:8] == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_md2; OUT_VALID && OUT_WORD.first |-> !OUT_WORD.data[2]; endproperty
  a_md2: assert property (p_md2) else $error("mode bit");
  property p_hi; OUT_VALID && OUT_WORD.first && OUT_READY |=> !OUT_VALID || OUT_WORD.data == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("word high");
  property p_fl; OUT_VALID && OUT_WORD.first |-> !OUT_WORD.last; endproperty
  a_fl: assert property (p_fl) else $error("first last");
  property p_lst; OUT_VALID && OUT_WORD.last && OUT_READY |=> !(OUT_VALID && OUT_WORD.last); endproperty
  a_lst: assert property (p_lst) else $error("last");
  property p_hold; OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_WORD); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule // discrete_event_packet_builder_props
bind discrete_event_packet_builder discrete_event_packet_builder_props i_props (.CLK(CLK), .RSTN(RSTN),
  .DATA_FORMAT(DATA_FORMAT), .PKT_FLAGS(PKT_FLAGS), .OUT_WORD(OUT_WORD), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));

// *** test/stream_sink_model.sv ***
// Stream sink standing in for the packet assembly logic
`timescale 1ns/100ps
module stream_sink_model (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, low
  input wire logic stall, // Slow acceptance
  output logic ready // Accept strobe
);
  logic ph_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_r <= 1'b0;
      ready <= 1'b0;
    end else begin
      ph_r <= !ph_r;
      ready <= !(stall && ph_r);
    end
  end
endmodule // stream_sink_model

// *** test/discrete_event_packet_builder_tb_top.sv ***
// Self-checking bench of the discrete packet builder
`timescale 1ns/100ps
module discrete_event_packet_builder_tb_top;
  logic clk, rstn, av_read, av_write, av_waitrequest, out_valid, out_ready, stall;
  logic [3:0] av_address, data_format;
  logic [31:0] av_writedata, av_readdata, disc_in, rd;
  logic [63:0] abs_time;
  logic [7:0] pkt_flags;
  logic [15:0] w [8];
  discrete_packet_pkg::word_s out_word;
  int n_mismatch = 0;
  int tests_run = 0;
  discrete_event_packet_builder i_dut (.CLK(clk), .RSTN(rstn), .AV_ADDRESS(av_address), .AV_READ(av_read),
    .AV_WRITE(av_write), .AV_WRITEDATA(av_writedata), .AV_BYTEENABLE(4'hF), .AV_READDATA(av_readdata),
    .AV_WAITREQUEST(av_waitrequest), .DISC_IN(disc_in), .ABS_TIME(abs_time), .DATA_FORMAT(data_format),
    .PKT_FLAGS(pkt_flags), .OUT_WORD(out_word), .OUT_VALID(out_valid), .OUT_READY(out_ready));
  stream_sink_model i_sink (.clk(clk), .rstn(rstn), .stall(stall), .ready(out_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    av_address <= a;
    av_writedata <= d;
    av_write <= wr;
    av_read <= !wr;
    do @(posedge clk); while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic grab();
    for (int i = 0; i < 8; i++) begin
      do @(posedge clk); while (!(out_valid === 1'b1 && out_ready === 1'b1));
      w[i] = out_word.data;
      chk({out_word.first, out_word.last}, {i == 0, i == 7});
    end
  endtask
  task automatic t_regs();
    chk(data_format, 32'h0000_0001);
    av(1'b1, 4'h0, 32'h0000_0004);
    av(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    av(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_0028);
    av(1'b0, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task automatic t_change();
    disc_in <= 32'hA5C3_F00F;
    av(1'b1, 4'h0, 32'h0000_0100);
    grab();
    chk(w[0], 32'h0000_0000);
    chk(w[1], 32'h0000_0000);
    chk(w[5], 32'h0000_0000);
    chk(w[6], 32'h0000_F00F);
    chk(w[7], 32'h0000_A5C3);
    disc_in <= 32'hA5C3_F00E;
    grab();
    chk(w[6], 32'h0000_F00E);
    $display("t_change done");
  endtask
  task automatic t_msb_abs();
    stall <= 1'b1;
    abs_time <= 64'h1122_3344_5566_7788;
    av(1'b1, 4'h0, 32'h0000_0000);
    av(1'b1, 4'h0, 32'h0000_0B43);
    chk(pkt_flags, 32'h0000_0048);
    grab();
    chk(w[0], 32'h0000_0043);
    chk(w[2], 32'h0000_7788);
    chk(w[5], 32'h0000_1122);
    chk(w[6], 32'h0000_0000);
    chk(w[7], 32'h0000_0E00);
    grab();
    chk(w[7], 32'h0000_0E00);
    av(1'b1, 4'h0, 32'h0000_0000);
    $display("t_msb_abs done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rstn, av_read, av_write, stall} = 4'h0;
    av_address = 4'h0;
    av_writedata = 32'h0000_0000;
    disc_in = 32'h0000_0000;
    abs_time = 64'h0000_0000_0000_0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_change();
    t_msb_abs();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule // discrete_event_packet_builder_tb_top
